// ---- tccp_pkg.sv ----
// Constants for the timer compare, capture and PWM block
// How it works
// - A 16-bit compare value is checked against the count on every timer tick.
// - Compare high byte writes go to staging; low byte write loads both bytes.
// - Selected capture edge copies the count into capture and sets capture flag.
// - Capture value is 16 bits, read-only, zero after reset.
// - Capture low read copies high byte to staging; high read returns staging.
// - PWM mode counts up from zero to top, then down, repeating.
// - Top is 255, 511 or 1023 for 8-, 9- or 10-bit resolution.
// - PWM compares only the low 8, 9 or 10 compare bits.
// - PWM code 10 clears on up match, sets on down; 11 reversed.
// - PWM compare writes go to a holding copy, loaded at top.
// - While held, compare reads return the holding copy.
// - Compare of zero or top drives a fixed level on the next match.
// - Compare equal to top gives no pulse with the undivided clock.
// - PWM sets overflow flag when counting away from zero; flags as normal.
// - Compare pin level before its first update is low, as reset clears it.
// - Edge select zero captures falling edges, one captures rising edges.
// - Noise filter needs four equal successive samples before a capture.
// - PWM select 00 off, 01/10/11 choose 8/9/10-bit PWM.
// - Clock select: stop, undivided, /8, /64, /256, /1024, pin fall, pin rise.
package tccp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAP_LO = 8'h24;
  localparam logic [7:0] IDX_CAP_HI = 8'h25;
  localparam logic [7:0] IDX_CMP_LO = 8'h2a;
  localparam logic [7:0] IDX_CMP_HI = 8'h2b;
  localparam logic [7:0] IDX_CNT_LO = 8'h2c;
  localparam logic [7:0] IDX_CNT_HI = 8'h2d;
  localparam logic [7:0] IDX_CTRL_B = 8'h2e;
  localparam logic [7:0] IDX_CTRL_A = 8'h2f;
  localparam logic [7:0] IDX_FLAGS = 8'h38;
  // Field positions
  localparam int CA_MODE_LSB = 6;
  localparam int CA_PWM_LSB = 0;
  localparam int CB_NOISE = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_CTC = 3;
  localparam int CB_CS_LSB = 0;
  localparam int FL_CAP = 3;
  localparam int FL_CMP = 4;
  localparam int FL_OVF = 7;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] STAGE_RST = 8'h00;
  // Tops per resolution
  localparam logic [15:0] TOP8 = 16'h00ff;
  localparam logic [15:0] TOP9 = 16'h01ff;
  localparam logic [15:0] TOP10 = 16'h03ff;
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8 = 2'h1;
  localparam logic [1:0] PWM_9 = 2'h2;
  localparam logic [1:0] COM_TOG = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Prescaler tick masks
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M64 = 10'h03f;
  localparam logic [9:0] PRE_M256 = 10'h0ff;
  localparam logic [9:0] PRE_M1024 = 10'h3ff;
  typedef enum logic [1:0] {TCCP_UP = 2'b01, TCCP_DOWN = 2'b10} tccp_dir_e;
endpackage

// ---- tccp_top.sv ----
// Timer compare, capture and PWM logic with APB register access
`timescale 1ns/1ps
module tccp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic count_pin,
  output logic compare_out_pin,
  output logic compare_out_en
);

////////////////////////////////////////////////////////////////////////
// Declarations

logic pready_q, pready_d, slverr_q, slverr_d;
logic [7:0] rdata_q, rdata_d;
logic [7:0] stage_q, stage_d;
logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, flags_q, flags_d;
logic [15:0] cnt_q, cnt_d, cmp_q, cmp_d, cap_q, cap_d;
logic [9:0] hold_q, hold_d;
logic [9:0] pre_q;
tccp_pkg::tccp_dir_e dir_q, dir_d;
logic [7:0] set_v;
logic out_q, out_d, out_en_q;
logic [1:0] cap_sync_q, ext_sync_q;
logic [3:0] hist_q;
logic lvl_q, lvl_d, ext_prev_q;
logic [7:0] idx;
logic acc, mapped, wr_do, rd_do, tick, match, cap_evt, pwm_on, top_turn;
logic [1:0] com, pwm;
logic [15:0] top, cmp_eff, cmp_view;

function automatic logic is_mapped(input logic [7:0] i);
  case (i)
    tccp_pkg::IDX_CAP_LO, tccp_pkg::IDX_CAP_HI, tccp_pkg::IDX_CMP_LO, tccp_pkg::IDX_CMP_HI,
    tccp_pkg::IDX_CNT_LO, tccp_pkg::IDX_CNT_HI, tccp_pkg::IDX_CTRL_A, tccp_pkg::IDX_CTRL_B,
    tccp_pkg::IDX_FLAGS: is_mapped = 1'b1;
    default: is_mapped = 1'b0;
  endcase
endfunction

////////////////////////////////////////////////////////////////////////
// Synchronisers and decode

always_ff @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cap_sync_q <= 2'h0;
    ext_sync_q <= 2'h0;
    hist_q <= 4'h0;
    ext_prev_q <= 1'b0;
    pre_q <= 10'h000;
  end else begin
    cap_sync_q <= {cap_sync_q[0], capture_pin};
    ext_sync_q <= {ext_sync_q[0], count_pin};
    hist_q <= {hist_q[2:0], cap_sync_q[1]};
    ext_prev_q <= ext_sync_q[1];
    pre_q <= pre_q + 10'h001;
  end
end

assign com = ctrl_a_q[tccp_pkg::CA_MODE_LSB +: 2];
assign pwm = ctrl_a_q[tccp_pkg::CA_PWM_LSB +: 2];
assign pwm_on = (pwm != tccp_pkg::PWM_OFF);
assign idx = paddr[9:2];
assign acc = psel & penable;
assign mapped = is_mapped(idx) & (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0);
// Side effects land only on the completing edge
assign wr_do = acc & pready_q & pwrite & pstrb[0] & mapped;
assign rd_do = acc & pready_q & ~pwrite & mapped;

always_comb begin
  case (pwm)
    tccp_pkg::PWM_8: top = tccp_pkg::TOP8;
    tccp_pkg::PWM_9: top = tccp_pkg::TOP9;
    default: top = tccp_pkg::TOP10;
  endcase
end

always_comb begin
  case (ctrl_b_q[tccp_pkg::CB_CS_LSB +: 3])
    tccp_pkg::CS_DIV1: tick = 1'b1;
    tccp_pkg::CS_DIV8: tick = (pre_q & tccp_pkg::PRE_M8) == tccp_pkg::PRE_M8;
    tccp_pkg::CS_DIV64: tick = (pre_q & tccp_pkg::PRE_M64) == tccp_pkg::PRE_M64;
    tccp_pkg::CS_DIV256: tick = (pre_q & tccp_pkg::PRE_M256) == tccp_pkg::PRE_M256;
    tccp_pkg::CS_DIV1024: tick = pre_q == tccp_pkg::PRE_M1024;
    tccp_pkg::CS_EXT_FALL: tick = ext_prev_q & ~ext_sync_q[1];
    tccp_pkg::CS_EXT_RISE: tick = ~ext_prev_q & ext_sync_q[1];
    default: tick = 1'b0;
  endcase
end

// PWM compares only the resolution's low bits
assign cmp_eff = pwm_on ? (cmp_q & top) : cmp_q;
assign match = tick & (cnt_q == cmp_eff);
assign cmp_view = pwm_on ? {cmp_q[15:10], hold_q} : cmp_q;
assign top_turn = tick & pwm_on & (dir_q == tccp_pkg::TCCP_UP) & (cnt_q == top);

////////////////////////////////////////////////////////////////////////
// Capture input

always_comb begin
  lvl_d = lvl_q;
  if (ctrl_b_q[tccp_pkg::CB_NOISE]) begin
    // Level moves only after four equal samples
    if (hist_q == 4'hf) begin
      lvl_d = 1'b1;
    end else if (hist_q == 4'h0) begin
      lvl_d = 1'b0;
    end
  end else begin
    lvl_d = cap_sync_q[1];
  end
  cap_evt = ctrl_b_q[tccp_pkg::CB_EDGE] ? (lvl_d & ~lvl_q) : (~lvl_d & lvl_q);
end

always_ff @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    lvl_q <= 1'b0;
  end else begin
    lvl_q <= lvl_d;
  end
end

////////////////////////////////////////////////////////////////////////
// APB answer: pready one cycle into the access phase

always_comb begin
  pready_d = acc & ~pready_q;
  slverr_d = acc & ~pready_q & ~mapped;
  rdata_d = rdata_q;
  if (acc & ~pready_q) begin
    case (idx)
      tccp_pkg::IDX_CAP_LO: rdata_d = cap_q[7:0];
      tccp_pkg::IDX_CAP_HI: rdata_d = stage_q;
      tccp_pkg::IDX_CMP_LO: rdata_d = cmp_view[7:0];
      tccp_pkg::IDX_CMP_HI: rdata_d = cmp_view[15:8];
      tccp_pkg::IDX_CNT_LO: rdata_d = cnt_q[7:0];
      tccp_pkg::IDX_CNT_HI: rdata_d = stage_q;
      tccp_pkg::IDX_CTRL_A: rdata_d = {com, 4'h0, pwm};
      tccp_pkg::IDX_CTRL_B: rdata_d = {ctrl_b_q[7:6], 2'h0, ctrl_b_q[3:0]};
      tccp_pkg::IDX_FLAGS: rdata_d = flags_q;
      default: rdata_d = 8'h00;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Timer, compare, capture and staging

always_comb begin
  cnt_d = cnt_q;
  dir_d = dir_q;
  cmp_d = cmp_q;
  hold_d = hold_q;
  cap_d = cap_q;
  stage_d = stage_q;
  out_d = out_q;
  ctrl_a_d = ctrl_a_q;
  ctrl_b_d = ctrl_b_q;
  flags_d = flags_q;
  // Flag sets are gathered first so a clear cannot lose them
  set_v = 8'h00;
  if (cap_evt) begin
    cap_d = cnt_q;
  end
  if (!pwm_on) begin
    dir_d = tccp_pkg::TCCP_UP;
    if (tick) begin
      if (match & ctrl_b_q[tccp_pkg::CB_CTC]) begin
        cnt_d = 16'h0000;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
      if (cnt_q == 16'hffff) begin
        set_v[tccp_pkg::FL_OVF] = 1'b1;
      end
    end
    if (match) begin
      case (com)
        tccp_pkg::COM_TOG: out_d = ~out_q;
        tccp_pkg::COM_CLR: out_d = 1'b0;
        tccp_pkg::COM_SET: out_d = 1'b1;
        default: out_d = out_q;
      endcase
    end
  end else if (tick) begin
    if (dir_q == tccp_pkg::TCCP_UP) begin
      if (cnt_q == top) begin
        dir_d = tccp_pkg::TCCP_DOWN;
        cnt_d = cnt_q - 16'h0001;
        cmp_d[9:0] = hold_q;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else begin
      if (cnt_q == 16'h0000) begin
        dir_d = tccp_pkg::TCCP_UP;
        cnt_d = 16'h0001;
        set_v[tccp_pkg::FL_OVF] = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    if (match & com[1]) begin
      // Zero and top give a steady level, so no pulse at top
      if (cmp_eff == 16'h0000) begin
        out_d = (com == tccp_pkg::COM_SET);
      end else if (cmp_eff == top) begin
        out_d = (com == tccp_pkg::COM_CLR);
      end else if (dir_q == tccp_pkg::TCCP_UP) begin
        out_d = (com == tccp_pkg::COM_SET);
      end else begin
        out_d = (com == tccp_pkg::COM_CLR);
      end
    end
  end
  if (match) begin
    set_v[tccp_pkg::FL_CMP] = 1'b1;
  end
  if (cap_evt) begin
    set_v[tccp_pkg::FL_CAP] = 1'b1;
  end
  // Software clears flags by writing ones; a same-cycle set wins
  if (wr_do && idx == tccp_pkg::IDX_FLAGS) begin
    flags_d = flags_q & ~pwdata[7:0];
  end
  flags_d = flags_d | set_v;
  if (wr_do) begin
    case (idx)
      tccp_pkg::IDX_CMP_HI, tccp_pkg::IDX_CNT_HI: stage_d = pwdata[7:0];
      tccp_pkg::IDX_CMP_LO: begin
        hold_d = {stage_q[1:0], pwdata[7:0]};
        cmp_d[15:10] = stage_q[7:2];
        if (!pwm_on) begin
          cmp_d[9:0] = {stage_q[1:0], pwdata[7:0]};
        end
      end
      tccp_pkg::IDX_CNT_LO: cnt_d = {stage_q, pwdata[7:0]};
      tccp_pkg::IDX_CTRL_A: ctrl_a_d = {pwdata[7:6], 4'h0, pwdata[1:0]};
      tccp_pkg::IDX_CTRL_B: ctrl_b_d = {pwdata[7:6], 2'h0, pwdata[3:0]};
      default: stage_d = stage_q;
    endcase
  end
  if (rd_do) begin
    case (idx)
      tccp_pkg::IDX_CAP_LO: stage_d = cap_q[15:8];
      tccp_pkg::IDX_CNT_LO: stage_d = cnt_q[15:8];
      default: stage_d = stage_d;
    endcase
  end
end

always_ff @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready_q <= 1'b0;
    slverr_q <= 1'b0;
    rdata_q <= 8'h00;
    stage_q <= tccp_pkg::STAGE_RST;
    ctrl_a_q <= tccp_pkg::CTRL_RST;
    ctrl_b_q <= tccp_pkg::CTRL_RST;
    flags_q <= tccp_pkg::CTRL_RST;
    cnt_q <= tccp_pkg::CNT_RST;
    cmp_q <= tccp_pkg::CMP_RST;
    hold_q <= tccp_pkg::CMP_RST[9:0];
    cap_q <= tccp_pkg::CAP_RST;
    dir_q <= tccp_pkg::TCCP_UP;
    // Level is low until the first compare update
    out_q <= 1'b0;
    out_en_q <= 1'b0;
  end else begin
    pready_q <= pready_d;
    slverr_q <= slverr_d;
    rdata_q <= rdata_d;
    stage_q <= stage_d;
    ctrl_a_q <= ctrl_a_d;
    ctrl_b_q <= ctrl_b_d;
    flags_q <= flags_d;
    cnt_q <= cnt_d;
    cmp_q <= cmp_d;
    hold_q <= hold_d;
    cap_q <= cap_d;
    dir_q <= dir_d;
    out_q <= out_d;
    out_en_q <= pwm_on ? com[1] : (com != 2'h0);
  end
end

assign pready = pready_q;
assign pslverr = slverr_q;
assign prdata = {24'h000000, rdata_q};
assign compare_out_pin = out_q;
assign compare_out_en = out_en_q;

////////////////////////////////////////////////////////////////////////
// Assertions

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

sequence s_setup;
  psel && !penable;
endsequence
sequence s_access;
  psel && penable;
endsequence

a_apb_ready_time: assert property (s_setup ##1 s_access |=> pready_q)
  else $error("pready not high in second access cycle");
a_cmp_low_load: assert property (wr_do && idx == tccp_pkg::IDX_CMP_LO && !pwm_on |=>
  cmp_q == {$past(stage_q), $past(pwdata[7:0])})
  else $error("compare low write did not load both bytes");
a_cmp_high_stage: assert property (wr_do && idx == tccp_pkg::IDX_CMP_HI && !pwm_on |=>
  stage_q == $past(pwdata[7:0]) && $stable(cmp_q))
  else $error("compare high write touched compare value");
a_capture_load: assert property (cap_evt |=> cap_q == $past(cnt_q) && flags_q[tccp_pkg::FL_CAP])
  else $error("capture did not load count and flag");
a_cap_low_stage: assert property (rd_do && idx == tccp_pkg::IDX_CAP_LO |=> stage_q == $past(cap_q[15:8]))
  else $error("capture low read did not stage high byte");
a_pwm_top_turn: assert property (top_turn && !wr_do |=>
  dir_q == tccp_pkg::TCCP_DOWN && cnt_q == $past(top) - 16'h0001 && cmp_q[9:0] == $past(hold_q))
  else $error("no turn or latch at top");
a_pwm_clear_up: assert property (match && pwm_on && com == tccp_pkg::COM_CLR && dir_q == tccp_pkg::TCCP_UP &&
  cmp_eff != 16'h0000 && cmp_eff != top |=> !out_q)
  else $error("non-inverted output not cleared on up match");
a_ovf_from_zero: assert property (tick && pwm_on && dir_q == tccp_pkg::TCCP_DOWN && cnt_q == 16'h0000 && !wr_do |=>
  flags_q[tccp_pkg::FL_OVF] && cnt_q == 16'h0001 && dir_q == tccp_pkg::TCCP_UP)
  else $error("overflow not set leaving zero");
a_filter_four: assert property (cap_evt && ctrl_b_q[tccp_pkg::CB_NOISE] |->
  hist_q == {4{ctrl_b_q[tccp_pkg::CB_EDGE]}})
  else $error("filtered capture without four equal samples");

endmodule

// ---- tccp_apb_master.sv ----
// APB master model standing in for the processor core
`timescale 1ns/1ps
module tccp_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////
  // One byte access; the core writes high before low and reads low before high
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err, output logic tmo);
    int n;
    tmo = 1'b1;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge, for at most 20 edges before a timeout
    for (n = 0; n < 20 && tmo; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) tmo = 1'b0;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the timer compare, capture and PWM block
`timescale 1ns/1ps
`define CHK(g, x) chk(32'(g), 32'(x))
`define RD(r) acc(1'b0, tccp_pkg::r, 8'h00)
`define WR(r, v) acc(1'b1, tccp_pkg::r, v)
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic capture_pin, count_pin, compare_out_pin, compare_out_en;
  int failures = 0;
  int tests_run = 0;
  int hi;
  logic [7:0] d;
  logic e;
  logic last;
  logic [15:0] top;
  typedef struct {logic [1:0] sel; logic [1:0] mode; logic [15:0] cmp;} tccp_row_s;
  // Steady levels at zero and top, upper bits ignored, unconnected codes
  tccp_row_s rows[8] = '{'{2'h1, 2'h2, 16'h0080}, '{2'h1, 2'h3, 16'h0180}, '{2'h2, 2'h2, 16'h0000},
    '{2'h2, 2'h3, 16'h01ff}, '{2'h3, 2'h2, 16'h03ff}, '{2'h3, 2'h3, 16'h0100}, '{2'h1, 2'h0, 16'h0010},
    '{2'h1, 2'h1, 16'h0010}};

  tccp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .capture_pin(capture_pin), .count_pin(count_pin), .compare_out_pin(compare_out_pin),
    .compare_out_en(compare_out_en));
  tccp_apb_master core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    logic t;
    core.xfer(w, idx, wd, d, e, t);
    if (t) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic pin(input logic v, input int n);
    @(posedge pclk);
    capture_pin <= v;
    repeat (n) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    capture_pin = 1'b1;
    count_pin = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `WR(IDX_CAP_LO, 8'hff);
    `RD(IDX_CAP_LO);
    `CHK(d, 8'h00);
    `RD(IDX_CAP_HI);
    `CHK(d, 8'h00);
    acc(1'b0, 8'h30, 8'h00);
    `CHK({e, d}, 9'h100);
    `WR(IDX_CMP_HI, 8'h12);
    `RD(IDX_CMP_HI);
    `CHK(d, 8'h00);
    `WR(IDX_CMP_LO, 8'h34);
    `RD(IDX_CMP_HI);
    `CHK(d, 8'h12);
    `RD(IDX_CMP_LO);
    `CHK(d, 8'h34);
    // Timer stopped so the captured count is known exactly
    `WR(IDX_CTRL_B, 8'h40);
    `WR(IDX_CNT_HI, 8'h12);
    `WR(IDX_CNT_LO, 8'h34);
    pin(1'b0, 8);
    `RD(IDX_FLAGS);
    `CHK(d[tccp_pkg::FL_CAP], 1'b0);
    pin(1'b1, 8);
    `RD(IDX_FLAGS);
    `CHK(d[tccp_pkg::FL_CAP], 1'b1);
    `RD(IDX_CAP_LO);
    `CHK(d, 8'h34);
    `RD(IDX_CAP_HI);
    `CHK(d, 8'h12);
    `RD(IDX_CAP_LO);
    `WR(IDX_CMP_HI, 8'h5a);
    `RD(IDX_CAP_HI);
    `CHK(d, 8'h5a);
    `WR(IDX_FLAGS, 8'hff);
    `WR(IDX_CTRL_B, 8'h80);
    `WR(IDX_CNT_HI, 8'h56);
    `WR(IDX_CNT_LO, 8'h78);
    pin(1'b0, 2);
    pin(1'b1, 8);
    `RD(IDX_FLAGS);
    `CHK(d[tccp_pkg::FL_CAP], 1'b0);
    pin(1'b0, 10);
    `RD(IDX_FLAGS);
    `CHK(d[tccp_pkg::FL_CAP], 1'b1);
    `RD(IDX_CAP_LO);
    `CHK(d, 8'h78);
    `RD(IDX_CAP_HI);
    `CHK(d, 8'h56);
    `RD(IDX_CNT_LO);
    `CHK(d, 8'h78);
    // Normal mode: toggle on match, clear on match, ticks every eighth clock
    `WR(IDX_CTRL_A, 8'h40);
    `WR(IDX_CMP_HI, 8'h00);
    `WR(IDX_CMP_LO, 8'h10);
    `WR(IDX_CNT_HI, 8'h00);
    `WR(IDX_CNT_LO, 8'h00);
    `WR(IDX_FLAGS, 8'hff);
    `WR(IDX_CTRL_B, {4'h0, 1'b1, tccp_pkg::CS_DIV8});
    repeat (300) @(posedge pclk);
    // 17 ticks of 8 clocks per match, so two matches in 272 clocks
    hi = 0;
    @(negedge pclk);
    last = compare_out_pin;
    repeat (272) begin
      @(negedge pclk);
      if (compare_out_pin !== last) hi++;
      last = compare_out_pin;
    end
    `CHK(hi, 2);
    `CHK(compare_out_en, 1'b1);
    `RD(IDX_FLAGS);
    `CHK(d[tccp_pkg::FL_CMP], 1'b1);
    `RD(IDX_CNT_LO);
    `CHK(d <= 8'h10, 1'b1);
    // External count pin, rising edges only
    `WR(IDX_CTRL_B, {5'h00, tccp_pkg::CS_EXT_RISE});
    `WR(IDX_CNT_HI, 8'h00);
    `WR(IDX_CNT_LO, 8'h00);
    repeat (10) begin
      @(posedge pclk);
      count_pin <= ~count_pin;
      repeat (3) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    `RD(IDX_CNT_LO);
    `CHK(d, 8'h05);
    foreach (rows[k]) begin
      top = (rows[k].sel == tccp_pkg::PWM_8) ? tccp_pkg::TOP8 :
            (rows[k].sel == tccp_pkg::PWM_9) ? tccp_pkg::TOP9 : tccp_pkg::TOP10;
      // Stop and zero the count so a smaller top is never overshot
      `WR(IDX_CTRL_B, 8'h00);
      `WR(IDX_CNT_HI, 8'h00);
      `WR(IDX_CNT_LO, 8'h00);
      `WR(IDX_CTRL_A, {rows[k].mode, 4'h0, rows[k].sel});
      `WR(IDX_CMP_HI, rows[k].cmp[15:8]);
      `WR(IDX_CMP_LO, rows[k].cmp[7:0]);
      `WR(IDX_CTRL_B, {5'h00, tccp_pkg::CS_DIV1});
      repeat (4 * top) @(posedge pclk);
      // High time over one full period does not depend on the start phase
      hi = 0;
      repeat (2 * top) begin
        @(negedge pclk);
        if (compare_out_pin === 1'b1) hi++;
      end
      `CHK(compare_out_en, rows[k].mode[1]);
      if (rows[k].mode == 2'h2) `CHK(hi, 2 * (rows[k].cmp & top));
      if (rows[k].mode == 2'h3) `CHK(hi, 2 * (top - (rows[k].cmp & top)));
      `WR(IDX_CMP_LO, 8'h0f);
      `RD(IDX_CMP_LO);
      `CHK(d, 8'h0f);
      `WR(IDX_FLAGS, 8'hff);
      repeat (2 * top + 4) @(posedge pclk);
      `RD(IDX_FLAGS);
      `CHK(d[tccp_pkg::FL_OVF], 1'b1);
    end
    complete_run();
  end
endmodule
